// ==== rtl/nrps_pkg.sv ====
// nrps_pkg: command bytes, register map, timing and op decode for the nand host sequencer
package nrps_pkg;
  localparam int         CLK_MHZ  = 200;
  localparam int         T_SU_NS  = 5;
  localparam int         T_WP_NS  = 15;
  localparam int         T_WH_NS  = 10;
  localparam int         T_REA_NS = 20;
  localparam int         T_WHR_NS = 60;
  localparam int         T_WB_NS  = 100;
  localparam int         SYNC_CYC = 2;
  localparam logic [7:0] SU_CYC   = 8'((T_SU_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] WP_CYC   = 8'((T_WP_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] WH_CYC   = 8'((T_WH_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] RP_CYC   = 8'((T_REA_NS * CLK_MHZ + 999) / 1000 + SYNC_CYC + 1);
  localparam logic [7:0] WHR_CYC  = 8'((T_WHR_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] TWB_CYC  = 8'((T_WB_NS * CLK_MHZ + 999) / 1000);
  // command bytes
  localparam logic [7:0] C_READ = 8'h00, C_READ_GO = 8'h30, C_CREAD = 8'h31, C_CLAST = 8'h3F;
  localparam logic [7:0] C_MREAD = 8'h60, C_LOAD = 8'h80, C_LOAD2 = 8'h81, C_COL = 8'h85;
  localparam logic [7:0] C_PROG = 8'h10, C_PLANE = 8'h11, C_CPROG = 8'h15;
  localparam logic [7:0] C_STAT = 8'h70, C_STAT2 = 8'hF1;
  // register map and fields
  localparam logic [7:0] R_CTRL = 8'h00, R_STATUS = 8'h04, R_COL = 8'h08, R_PAGE = 8'h0C;
  localparam logic [7:0] R_PAGE2 = 8'h10, R_DATA = 8'h14, R_CFG = 8'h18;
  localparam int         CTRL_GO = 4, CFG_WP = 0;
  localparam int         ST_BUSY = 0, ST_READY = 1, ST_REFUSED = 2, ST_CPROG = 3, ST_PLANE = 4, ST_COL = 18;
  localparam int         COL_W = 14, PAGE_W = 19, BLK_LSB = 6;

  typedef enum logic [3:0] {
    OP_READ, OP_READ_PON, OP_CACHE_READ, OP_CACHE_LAST, OP_MREAD_HALF, OP_MREAD_GO,
    OP_PROG_LOAD, OP_COL_CHANGE, OP_PROG_CONFIRM, OP_PROG_PLANE1, OP_PROG_PLANE2,
    OP_CACHE_PROG, OP_STATUS, OP_STATUS2, OP_DATA_IN, OP_DATA_OUT
  } nrps_op_t;

  typedef enum logic [2:0] {S_IDLE, S_C1, S_ADDR, S_C2, S_TWB, S_RDY, S_DIN, S_DOUT} nrps_st_t;

  typedef struct packed {
    logic       c1;
    logic [7:0] b1;
    logic [2:0] na;
    logic       p2;
    logic       c2;
    logic [7:0] b2;
    logic       wt;
    logic       din;
    logic       dout;
  } nrps_dec_t;

  // pin sequence of each op: first command, address count, second command, wait, data
  function automatic nrps_dec_t nrps_decode(nrps_op_t op);
    case (op)
      OP_READ:         return {1'h1, C_READ, 3'h5, 1'h0, 1'h1, C_READ_GO, 1'h1, 1'h0, 1'h0};
      OP_READ_PON:     return {1'h0, C_READ, 3'h5, 1'h0, 1'h1, C_READ_GO, 1'h1, 1'h0, 1'h0};
      OP_CACHE_READ:   return {1'h1, C_CREAD, 3'h0, 1'h0, 1'h0, 8'h00, 1'h1, 1'h0, 1'h0};
      OP_CACHE_LAST:   return {1'h1, C_CLAST, 3'h0, 1'h0, 1'h0, 8'h00, 1'h1, 1'h0, 1'h0};
      OP_MREAD_HALF:   return {1'h1, C_MREAD, 3'h5, 1'h0, 1'h0, 8'h00, 1'h0, 1'h0, 1'h0};
      OP_MREAD_GO:     return {1'h1, C_MREAD, 3'h5, 1'h1, 1'h1, C_READ_GO, 1'h1, 1'h0, 1'h0};
      OP_PROG_LOAD:    return {1'h1, C_LOAD, 3'h5, 1'h0, 1'h0, 8'h00, 1'h0, 1'h0, 1'h0};
      OP_COL_CHANGE:   return {1'h1, C_COL, 3'h2, 1'h0, 1'h0, 8'h00, 1'h0, 1'h0, 1'h0};
      OP_PROG_CONFIRM: return {1'h1, C_PROG, 3'h0, 1'h0, 1'h0, 8'h00, 1'h1, 1'h0, 1'h0};
      OP_PROG_PLANE1:  return {1'h1, C_PLANE, 3'h0, 1'h0, 1'h0, 8'h00, 1'h1, 1'h0, 1'h0};
      OP_PROG_PLANE2:  return {1'h1, C_LOAD2, 3'h5, 1'h1, 1'h0, 8'h00, 1'h0, 1'h0, 1'h0};
      OP_CACHE_PROG:   return {1'h1, C_CPROG, 3'h0, 1'h0, 1'h0, 8'h00, 1'h1, 1'h0, 1'h0};
      OP_STATUS:       return {1'h1, C_STAT, 3'h0, 1'h0, 1'h0, 8'h00, 1'h0, 1'h0, 1'h1};
      OP_STATUS2:      return {1'h1, C_STAT2, 3'h0, 1'h0, 1'h0, 8'h00, 1'h0, 1'h0, 1'h1};
      OP_DATA_IN:      return {1'h0, 8'h00, 3'h0, 1'h0, 1'h0, 8'h00, 1'h0, 1'h1, 1'h0};
      default:         return {1'h0, 8'h00, 3'h0, 1'h0, 1'h0, 8'h00, 1'h0, 1'h0, 1'h1};
    endcase
  endfunction : nrps_decode

  // next state after a stage; lvl 0 start, 1 after command, 2 after address, 3 after confirm
  function automatic nrps_st_t seq_next(nrps_dec_t d, logic [1:0] lvl);
    if (lvl == 2'h0 && d.c1) return S_C1;
    if (lvl <= 2'h1 && d.na != 3'h0) return S_ADDR;
    if (lvl <= 2'h2 && d.c2) return S_C2;
    if (d.wt) return S_TWB;
    if (d.din) return S_DIN;
    if (d.dout) return S_DOUT;
    return S_IDLE;
  endfunction : seq_next
endpackage : nrps_pkg

// ==== rtl/nrps_host.sv ====
// nrps_host: apb-controlled host sequencer driving a nand flash over its pins
//
// The APB interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module nrps_host import nrps_pkg::*; (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // nand pins
  output logic             ce_n,
  output logic             cle,
  output logic             ale,
  output logic             we_n,
  output logic             read_strobe_n,
  output logic             wp_n,
  output logic      [7:0]  io_out,
  output logic             io_oe_n,
  input  wire logic [7:0]  io_in,
  input  wire logic        ready_busy_n
);
  nrps_st_t           st_q, st_d;
  nrps_op_t           op_q, op_d, wop;
  nrps_dec_t          dec, ndec;
  logic [1:0]         ph_q, ph_d;
  logic [7:0]         tc_q, tc_d, lim, abyte, io_q, io_d, rdb_q, rdb_d, wdat_q, wdat_d;
  logic [2:0]         ai_q, ai_d;
  logic               ce_n_q, ce_n_d, cle_q, cle_d, ale_q, ale_d, we_n_q, we_n_d;
  logic               re_n_q, re_n_d, oe_n_q, oe_n_d, wp_n_q;
  logic [COL_W-1:0]   col_q, col_d, colp_q, colp_d;
  logic [PAGE_W-1:0]  page_q, page_d, page2_q, page2_d, pg;
  logic [PAGE_W-1-BLK_LSB:0] rblk_q, rblk_d, pblk_q, pblk_d;
  logic               rdrun_q, rdrun_d, cprog_q, cprog_d, plane_q, plane_d;
  logic               wpen_q, wpen_d, refused_q, refused_d;
  logic               pready_q, pready_d, pslverr_q, pslverr_d;
  logic [31:0]        prdata_q, prdata_d, rd, stw;
  logic               acc, wr, idle, go, bad, rej, clr_ref, busy_wr, step_end, map;
  logic               rb_m_q, rb_s_q;
  logic [7:0]         io_m_q, io_s_q;

  assign prdata        = prdata_q;
  assign pready        = pready_q;
  assign pslverr       = pslverr_q;
  assign ce_n          = ce_n_q;
  assign cle           = cle_q;
  assign ale           = ale_q;
  assign we_n          = we_n_q;
  assign read_strobe_n = re_n_q;
  assign wp_n          = wp_n_q;
  assign io_out        = io_q;
  assign io_oe_n       = oe_n_q;

  // pin inputs cross into the clk domain through two stages
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rb_m_q <= 1'h0;
      rb_s_q <= 1'h0;
      io_m_q <= 8'h00;
      io_s_q <= 8'h00;
    end else begin
      rb_m_q <= ready_busy_n;
      rb_s_q <= rb_m_q;
      io_m_q <= io_in;
      io_s_q <= io_m_q;
    end
  end

  // apb slave: one wait state, writes land at the edge that samples pready
  always_comb begin
    pready_d  = psel && penable && !pready_q;
    acc       = psel && penable && pready_q;
    wr        = acc && pwrite;
    idle      = st_q == S_IDLE;
    go        = wr && paddr == R_CTRL && pwdata[CTRL_GO];
    wop       = nrps_op_t'(pwdata[3:0]);
    clr_ref   = wr && paddr == R_STATUS && pwdata[ST_REFUSED];
    map       = paddr <= R_CFG && paddr[1:0] == 2'h0;
    col_d     = col_q;
    page_d    = page_q;
    page2_d   = page2_q;
    wdat_d    = wdat_q;
    wpen_d    = wpen_q;
    // address and data registers feed the pins mid-op, so they are frozen while busy
    busy_wr   = wr && !idle && map && paddr != R_CTRL && paddr != R_STATUS;
    if (wr && idle) begin
      case (paddr)
        R_COL:   col_d   = pwdata[COL_W-1:0];
        R_PAGE:  page_d  = pwdata[PAGE_W-1:0];
        R_PAGE2: page2_d = pwdata[PAGE_W-1:0];
        R_DATA:  wdat_d  = pwdata[7:0];
        R_CFG:   wpen_d  = pwdata[CFG_WP];
        default: ;
      endcase
    end
    // a refusal in the clearing cycle survives
    refused_d = (refused_q && !clr_ref) || busy_wr || rej;
    stw                       = 32'h0000_0000;
    stw[ST_BUSY]              = !idle;
    stw[ST_READY]             = rb_s_q;
    stw[ST_REFUSED]           = refused_q;
    stw[ST_CPROG]             = cprog_q;
    stw[ST_PLANE]             = plane_q;
    stw[ST_COL +: COL_W]      = colp_q;
    case (paddr)
      R_CTRL:   rd = {28'h0, op_q};
      R_STATUS: rd = stw;
      R_COL:    rd = {18'h0, col_q};
      R_PAGE:   rd = {13'h0, page_q};
      R_PAGE2:  rd = {13'h0, page2_q};
      R_DATA:   rd = {24'h0, rdb_q};
      R_CFG:    rd = {31'h0, wpen_q};
      default:  rd = 32'h0000_0000;
    endcase
    prdata_d  = pready_d ? rd : prdata_q;
    pslverr_d = pready_d && !map;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pready_q  <= 1'h0;
      pslverr_q <= 1'h0;
      prdata_q  <= 32'h0000_0000;
      col_q     <= '0;
      page_q    <= '0;
      page2_q   <= '0;
      wdat_q    <= 8'h00;
      wpen_q    <= 1'h0;
      refused_q <= 1'h0;
    end else begin
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q  <= prdata_d;
      col_q     <= col_d;
      page_q    <= page_d;
      page2_q   <= page2_d;
      wdat_q    <= wdat_d;
      wpen_q    <= wpen_d;
      refused_q <= refused_d;
    end
  end

  // address byte order: column low, column high, then three page bytes
  always_comb begin
    pg = dec.p2 ? page2_q : page_q;
    case (ai_q)
      3'h0:    abyte = col_q[7:0];
      3'h1:    abyte = {2'h0, col_q[13:8]};
      3'h2:    abyte = pg[7:0];
      3'h3:    abyte = pg[15:8];
      default: abyte = {5'h00, pg[18:16]};
    endcase
  end

  // sequencer: each pin cycle is setup, strobe low, strobe high
  always_comb begin
    dec      = nrps_decode(op_q);
    ndec     = nrps_decode(wop);
    st_d     = st_q;
    op_d     = op_q;
    ph_d     = ph_q;
    tc_d     = tc_q + 8'h01;
    ai_d     = ai_q;
    cle_d    = 1'h0;
    ale_d    = 1'h0;
    we_n_d   = 1'h1;
    re_n_d   = 1'h1;
    oe_n_d   = 1'h1;
    io_d     = io_q;
    colp_d   = colp_q;
    rdb_d    = rdb_q;
    rblk_d   = rblk_q;
    pblk_d   = pblk_q;
    rdrun_d  = rdrun_q;
    cprog_d  = cprog_q;
    plane_d  = plane_q;
    case (ph_q)
      2'h0:    lim = (st_q == S_DOUT) ? WHR_CYC : SU_CYC;
      2'h1:    lim = (st_q == S_DOUT) ? RP_CYC : WP_CYC;
      default: lim = WH_CYC;
    endcase
    step_end = ph_q == 2'h2 && tc_q == lim - 8'h01;
    bad = (plane_q && wop != OP_STATUS && wop != OP_STATUS2 && wop != OP_PROG_PLANE2)
       || ((wop == OP_CACHE_READ || wop == OP_CACHE_LAST)
           && (!rdrun_q || page_q[PAGE_W-1:BLK_LSB] != rblk_q))
       || ((wop == OP_MREAD_GO || wop == OP_PROG_PLANE2)
           && (page_q[BLK_LSB-1:0] != page2_q[BLK_LSB-1:0]
               || page_q[BLK_LSB] == page2_q[BLK_LSB]))
       || ((wop == OP_MREAD_HALF || wop == OP_MREAD_GO) && wpen_q)
       || (wop == OP_PROG_LOAD && cprog_q && page_q[PAGE_W-1:BLK_LSB] != pblk_q);
    rej = go && (!idle || bad);
    case (st_q)
      S_IDLE: begin
        tc_d = 8'h00;
        ph_d = 2'h0;
        ai_d = 3'h0;
        if (go && !rej) begin
          op_d = wop;
          st_d = seq_next(ndec, 2'h0);
          if (wop == OP_READ || wop == OP_READ_PON) begin
            rdrun_d = 1'h1;
            rblk_d  = page_q[PAGE_W-1:BLK_LSB];
          end
          if (wop == OP_MREAD_HALF || wop == OP_MREAD_GO) rdrun_d = 1'h0;
          if (wop == OP_PROG_LOAD && !cprog_q) pblk_d = page_q[PAGE_W-1:BLK_LSB];
          if (wop == OP_CACHE_PROG) cprog_d = 1'h1;
          if (wop == OP_PROG_CONFIRM) cprog_d = 1'h0;
          if (wop == OP_PROG_PLANE1) plane_d = 1'h1;
          if (wop == OP_PROG_PLANE2) plane_d = 1'h0;
        end
      end
      S_C1, S_ADDR, S_C2, S_DIN: begin
        oe_n_d = 1'h0;
        cle_d  = st_q == S_C1 || st_q == S_C2;
        ale_d  = st_q == S_ADDR;
        we_n_d = ph_q != 2'h1;
        case (st_q)
          S_C1:    io_d = dec.b1;
          S_C2:    io_d = dec.b2;
          S_ADDR:  io_d = abyte;
          default: io_d = wdat_q;
        endcase
        if (tc_q == lim - 8'h01) begin
          tc_d = 8'h00;
          ph_d = (ph_q == 2'h2) ? 2'h0 : ph_q + 2'h1;
        end
        if (step_end) begin
          case (st_q)
            S_C1: st_d = seq_next(dec, 2'h1);
            S_ADDR: begin
              ai_d = ai_q + 3'h1;
              if (ai_q == dec.na - 3'h1) begin
                st_d   = seq_next(dec, 2'h2);
                colp_d = col_q;
              end
            end
            S_C2: st_d = seq_next(dec, 2'h3);
            default: begin
              colp_d = colp_q + 14'h0001;
              st_d   = S_IDLE;
            end
          endcase
        end
      end
      S_DOUT: begin
        re_n_d = ph_q != 2'h1;
        if (tc_q == lim - 8'h01) begin
          tc_d = 8'h00;
          ph_d = (ph_q == 2'h2) ? 2'h0 : ph_q + 2'h1;
          if (ph_q == 2'h1) rdb_d = io_s_q;
        end
        if (step_end) begin
          st_d = S_IDLE;
          if (op_q == OP_DATA_OUT) colp_d = colp_q + 14'h0001;
        end
      end
      // busy is not yet visible right after the confirm strobe
      S_TWB: if (tc_q == TWB_CYC - 8'h01) st_d = S_RDY;
      S_RDY: if (rb_s_q) st_d = S_IDLE;
      default: st_d = S_IDLE;
    endcase
    ce_n_d = st_d == S_IDLE;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q    <= S_IDLE;
      op_q    <= OP_READ;
      ph_q    <= 2'h0;
      tc_q    <= 8'h00;
      ai_q    <= 3'h0;
      ce_n_q  <= 1'h1;
      cle_q   <= 1'h0;
      ale_q   <= 1'h0;
      we_n_q  <= 1'h1;
      re_n_q  <= 1'h1;
      oe_n_q  <= 1'h1;
      wp_n_q  <= 1'h0;
      io_q    <= 8'h00;
      colp_q  <= '0;
      rdb_q   <= 8'h00;
      rblk_q  <= '0;
      pblk_q  <= '0;
      rdrun_q <= 1'h0;
      cprog_q <= 1'h0;
      plane_q <= 1'h0;
    end else begin
      st_q    <= st_d;
      op_q    <= op_d;
      ph_q    <= ph_d;
      tc_q    <= tc_d;
      ai_q    <= ai_d;
      ce_n_q  <= ce_n_d;
      cle_q   <= cle_d;
      ale_q   <= ale_d;
      we_n_q  <= we_n_d;
      re_n_q  <= re_n_d;
      oe_n_q  <= oe_n_d;
      wp_n_q  <= !wpen_q;
      io_q    <= io_d;
      colp_q  <= colp_d;
      rdb_q   <= rdb_d;
      rblk_q  <= rblk_d;
      pblk_q  <= pblk_d;
      rdrun_q <= rdrun_d;
      cprog_q <= cprog_d;
      plane_q <= plane_d;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_latch_excl: assert property (!(cle_q && ale_q)) else $error("cle and ale both high");
  a_we_with_ce: assert property (!we_n_q |-> !ce_n_q && re_n_q && !oe_n_q) else $error("write strobe bad");
  a_read_confirm: assert property (st_q == S_C2 && ph_q == 2'h2 && op_q != OP_MREAD_GO
    |-> cle_q && io_q == C_READ_GO) else $error("read confirm byte wrong");
  a_mread_confirm: assert property (st_q == S_C2 && ph_q == 2'h2 && op_q == OP_MREAD_GO
    |-> io_q == C_READ_GO && $past(st_q, 6) == S_ADDR) else $error("multi read confirm wrong");
  a_addr_bytes: assert property (st_q == S_ADDR && st_d != S_ADDR |-> ai_q == dec.na - 3'h1)
    else $error("address byte count wrong");
  a_wp_mread: assert property ((op_q == OP_MREAD_HALF || op_q == OP_MREAD_GO) && st_q != S_IDLE
    |-> wp_n_q) else $error("write protect low in multi read");
  a_plane_gap: assert property (go && plane_q && !rej
    |-> wop == OP_STATUS || wop == OP_STATUS2 || wop == OP_PROG_PLANE2) else $error("command between planes");
  a_mread_pages: assert property (go && !rej && wop == OP_MREAD_GO |=> page_q[5:0] == page2_q[5:0]
    && page_q[6] != page2_q[6]) else $error("multi read pages mismatch");
  a_cache_block: assert property (go && !rej && wop == OP_CACHE_READ
    |-> page_q[PAGE_W-1:BLK_LSB] == rblk_q && rdrun_q) else $error("cache read across block");
  a_cprog_block: assert property (go && !rej && wop == OP_PROG_LOAD && cprog_q
    |-> page_q[PAGE_W-1:BLK_LSB] == pblk_q) else $error("cache program across block");
  a_wait_ready: assert property (st_q == S_TWB && tc_q == 8'h00 |-> st_q == S_TWB [*8] ##13 st_q == S_RDY)
    else $error("busy wait too short");
  a_apb_answer: assert property (psel && penable && !pready_q |=> pready_q ##1 !pready_q)
    else $error("apb answer timing wrong");
endmodule : nrps_host
`default_nettype wire

// ==== verification/nrps_nand_model.sv ====
// nrps_nand_model: behavioural flash answering the host sequencer pins
`timescale 1ns/1ps
`default_nettype none
module nrps_nand_model #(
  parameter int BUSY_NS = 300
) (
  // control pins
  input  wire logic       ce_n,
  input  wire logic       cle,
  input  wire logic       ale,
  input  wire logic       we_n,
  input  wire logic       read_strobe_n,
  input  wire logic       wp_n,
  // data and status
  input  wire logic [7:0] io_out,
  input  wire logic       io_oe_n,
  output logic      [7:0] io_in,
  output logic            ready_busy_n
);
  logic [9:0]  log[$];
  logic [7:0]  cmd   = 8'h00; // power-on: read setup already latched
  logic [7:0]  dout  = 8'h00;
  logic [13:0] col   = 14'h0000;
  logic        rb    = 1'b1;
  logic        cfail = 1'b0;
  logic        pfail = 1'b0;
  logic        fail  = 1'b0;
  int          na    = 0;

  always @(posedge we_n) if (!ce_n) begin
    log.push_back({cle, ale, io_in});
    if (cle && !ale) begin
      cmd = io_out;
      na = 0;
      if (io_out inside {8'h30, 8'h31, 8'h3F, 8'h10, 8'h11, 8'h15}) begin
        pfail = cfail;
        cfail = fail;
        rb = 1'b0;
        rb <= #(BUSY_NS) 1'b1;
      end
    end else if (ale) begin
      if (na == 0) col[7:0] = io_out;
      if (na == 1) col[13:8] = io_out[5:0];
      na++;
    end
  end

  // status bits only meaningful with their ready bits set
  always @(negedge read_strobe_n) if (!ce_n)
    dout = (cmd == 8'h70 || cmd == 8'hF1) ? {wp_n, rb, rb, 3'h0, pfail, cfail} : col[7:0];
  always @(posedge read_strobe_n) if (!ce_n && cmd != 8'h70 && cmd != 8'hF1)
    col++;

  // released bus shows the inverse so a stale capture is caught
  assign io_in = !io_oe_n ? io_out : (!ce_n && !read_strobe_n) ? dout : ~dout;
  assign ready_busy_n = rb;
endmodule : nrps_nand_model
`default_nettype wire

// ==== verification/tb.sv ====
// tb: apb-driven checks of the nand host sequencer against the flash model
`timescale 1ns/1ps
`default_nettype none
module tb import nrps_pkg::*;;
  logic        clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00, io_out, io_in;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, ce_n, cle, ale, we_n, read_strobe_n, wp_n, io_oe_n, ready_busy_n, slv_err;
  int          errors = 0, total_checks = 0;

  nrps_host u_nrps_host (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ce_n(ce_n),
    .cle(cle), .ale(ale), .we_n(we_n), .read_strobe_n(read_strobe_n), .wp_n(wp_n), .io_out(io_out),
    .io_oe_n(io_oe_n), .io_in(io_in), .ready_busy_n(ready_busy_n));
  nrps_nand_model u_nrps_nand_model (.ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n),
    .read_strobe_n(read_strobe_n), .wp_n(wp_n), .io_out(io_out), .io_oe_n(io_oe_n), .io_in(io_in),
    .ready_busy_n(ready_busy_n));

  initial forever #2.5 clk = ~clk;

  task automatic summarize();
    $display("checks=%0d errors=%0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  // entered right after a rising edge; the slave decides the wait
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk) penable <= 1'b1;
    do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 50);
    q = prdata;
    slv_err = pslverr;
    chk({31'h0, pready}, 32'h1);
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask : wr

  task automatic op(input logic [3:0] c);
    logic [31:0] q;
    int n;
    n = 0;
    wr(R_CTRL, {27'h0, 1'b1, c});
    do begin apb(1'b0, R_STATUS, 32'h0, q); n++; end while (q[ST_BUSY] !== 1'b0 && n < 400);
    chk({30'h0, q[ST_READY], q[ST_BUSY]}, 32'h2);
  endtask : op

  task automatic pin(input logic [1:0] k, input logic [7:0] b);
    logic [9:0] g;
    g = (u_nrps_nand_model.log.size() > 0) ? u_nrps_nand_model.log.pop_front() : 10'h3FF;
    chk({22'h0, g}, {22'h0, k, b});
  endtask : pin

  task automatic addr5(input logic [13:0] c, input logic [18:0] p);
    pin(2'h1, c[7:0]);
    pin(2'h1, {2'h0, c[13:8]});
    pin(2'h1, p[7:0]);
    pin(2'h1, p[15:8]);
    pin(2'h1, {5'h0, p[18:16]});
  endtask : addr5

  task automatic at(input logic [13:0] c, input logic [18:0] p);
    wr(R_COL, {18'h0, c});
    wr(R_PAGE, {13'h0, p});
  endtask : at

  // refused op: flag set, nothing on the pins, flag cleared again
  task automatic refused();
    logic [31:0] q;
    apb(1'b0, R_STATUS, 32'h0, q);
    chk({31'h0, q[ST_REFUSED]}, 32'h1);
    wr(R_STATUS, 32'h4);
    chk(32'(u_nrps_nand_model.log.size()), 32'h0);
  endtask : refused

  task automatic rd_byte(input logic [7:0] e);
    logic [31:0] q;
    apb(1'b0, R_DATA, 32'h0, q);
    chk({24'h0, q[7:0]}, {24'h0, e});
  endtask : rd_byte

  task automatic s_regs();
    logic [31:0] q;
    chk({30'h0, ce_n, wp_n}, 32'h3);
    apb(1'b0, 8'h1C, 32'h0, q);
    chk({q[30:0], slv_err}, 32'h1);
  endtask : s_regs

  task automatic s_pon();
    at(14'h1234, 19'h5ABCD);
    op(4'h1);
    addr5(14'h1234, 19'h5ABCD);
    pin(2'h2, 8'h30);
    op(4'hF);
    rd_byte(8'h34);
    op(4'hF);
    rd_byte(8'h35);
  endtask : s_pon

  task automatic s_cache();
    at(14'h0, 19'h00080);
    op(4'h0);
    pin(2'h2, 8'h00);
    addr5(14'h0, 19'h00080);
    pin(2'h2, 8'h30);
    op(4'h2);
    pin(2'h2, 8'h31);
    op(4'h3);
    pin(2'h2, 8'h3F);
    wr(R_PAGE, 32'h000C0);
    op(4'h2);
    refused();
  endtask : s_cache

  task automatic s_mread();
    logic [18:0] pg[2];
    pg = '{19'h00105, 19'h00145}; // block 4 lies in district 0, block 5 in district 1
    wr(R_CFG, 32'h1);
    at(14'h0, pg[0]);
    wr(R_PAGE2, {13'h0, pg[1]});
    op(4'h4);
    refused();
    wr(R_CFG, 32'h0);
    wr(R_PAGE2, 32'h00146);
    op(4'h5);
    refused();
    for (int i = 0; i < 2; i++) begin
      at(14'h0, pg[i]);
      wr(R_PAGE2, {13'h0, pg[1-i]});
      op(4'h4);
      op(4'h5);
      chk({31'h0, wp_n}, 32'h1);
      pin(2'h2, 8'h60);
      addr5(14'h0, pg[i]);
      pin(2'h2, 8'h60);
      addr5(14'h0, pg[1-i]);
      pin(2'h2, 8'h30);
    end
  endtask : s_mread

  task automatic s_prog();
    at(14'h0010, 19'h00200);
    op(4'h6);
    wr(R_DATA, 32'hA5);
    op(4'hE);
    wr(R_COL, 32'h0300);
    op(4'h7);
    wr(R_DATA, 32'h5A);
    op(4'hE);
    op(4'h8);
    pin(2'h2, 8'h80);
    addr5(14'h0010, 19'h00200);
    pin(2'h0, 8'hA5);
    pin(2'h2, 8'h85);
    pin(2'h1, 8'h00);
    pin(2'h1, 8'h03);
    pin(2'h0, 8'h5A);
    pin(2'h2, 8'h10);
  endtask : s_prog

  task automatic s_plane();
    at(14'h0, 19'h00300);
    wr(R_PAGE2, 32'h00340);
    op(4'h6);
    op(4'h9);
    pin(2'h2, 8'h80);
    addr5(14'h0, 19'h00300);
    pin(2'h2, 8'h11);
    op(4'h6);
    refused();
    op(4'hC);
    pin(2'h2, 8'h70);
    rd_byte(8'hE0);
    op(4'hD);
    pin(2'h2, 8'hF1);
    rd_byte(8'hE0);
    u_nrps_nand_model.fail = 1'b1;
    op(4'hA);
    op(4'h8);
    u_nrps_nand_model.fail = 1'b0;
    op(4'hC);
    pin(2'h2, 8'h81);
    addr5(14'h0, 19'h00340);
    pin(2'h2, 8'h10);
    pin(2'h2, 8'h70);
    rd_byte(8'hE1);
  endtask : s_plane

  task automatic s_cprog();
    at(14'h0, 19'h00400);
    for (int i = 0; i < 2; i++) begin
      op(4'h6);
      u_nrps_nand_model.fail = (i == 1);
      op(4'hB);
      pin(2'h2, 8'h80);
      addr5(14'h0, 19'h00400);
      pin(2'h2, 8'h15);
    end
    u_nrps_nand_model.fail = 1'b0;
    wr(R_PAGE, 32'h00440);
    op(4'h6);
    refused();
    wr(R_PAGE, 32'h00402);
    op(4'h6);
    op(4'h8);
    op(4'hC);
    pin(2'h2, 8'h80);
    addr5(14'h0, 19'h00402);
    pin(2'h2, 8'h10);
    pin(2'h2, 8'h70);
    rd_byte(8'hE2);
  endtask : s_cprog

  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    // wp_n only rises at the first edge after release, so look one edge later
    repeat (2) @(posedge clk);
    s_regs();
    s_pon();
    s_cache();
    s_mread();
    s_prog();
    s_plane();
    s_cprog();
    summarize();
  end

  // run takes about 10 us; 100 us leaves a wide margin
  initial begin
    #100000;
    errors++;
    summarize();
  end
endmodule : tb
`default_nettype wire
